// ===== pafp_port_alt_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pafp_map.vh"
// alternate function pin control with dedicated strobe pad register
module pafp_port_alt_ctrl
(
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [15:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   input wire [15:0] alt_data_in,
   input wire [15:0] alt_pwm_in,
   input wire bus_active_in,
   input wire bus_drive_in,
   input wire [15:0] pad_in,
   output wire [15:0] pad_out,
   output wire [15:0] pad_oe_out,
   output wire [15:0] alt_in_out,
   output reg [1:0] strobe_edge_sel_out,
   output reg [1:0] strobe_drive_sel_out,
   output reg [1:0] latch_strobe_edge_sel_out,
   output reg [1:0] latch_strobe_drive_sel_out
);
   reg [7:0] dedicated_pad_ctrl;
   reg [15:0] port_latch;
   reg [15:0] pin_direction_bit;
   reg [15:0] alt_enable;
   reg [15:0] auto_out_mask;
   reg [15:0] hw_dir_en;
   reg [31:0] next_rdata;
   wire wb_req;
   wire wb_wr;
   wire [15:0] pad_out_w;
   wire [15:0] pad_oe_w;
   wire [15:0] alt_in_w;

   // reserved codes fall back to the safe default
   function [1:0] edge_code;
      input [1:0] code;
      begin
         edge_code = (code == `PAFP_EDGE_SLOW) ? `PAFP_EDGE_SLOW : `PAFP_EDGE_FAST;
      end
   endfunction

   function [1:0] drive_code;
      input [1:0] code;
      begin
         drive_code = (code == 2'h3) ? `PAFP_DRIVE_HIGH : code;
      end
   endfunction

   // byte lane merge for 16-bit registers
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] data;
      input [1:0] sel;
      begin
         merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // address decode shared by the write processes
   function hit;
      input [15:0] adr;
      input [15:0] target;
      begin
         hit = (adr == target);
      end
   endfunction

   // request not yet answered
   assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   // a write lands on the edge at which the master sees ack high
   assign wb_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;

   // dedicated strobe pad register, low byte lane only
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         dedicated_pad_ctrl <= `PAFP_PAD_CTRL_RESET;
      end
      else if (wb_wr && hit(wb_adr_in, `PAFP_PAD_CTRL_ADDR) && wb_sel_in[0])
      begin
         dedicated_pad_ctrl <= wb_dat_in[7:0];
      end
   end

   // port output latch, byte lanes merged
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         port_latch <= 16'h0000;
      end
      else if (wb_wr && hit(wb_adr_in, `PAFP_LATCH_ADDR))
      begin
         port_latch <= merge16(port_latch, wb_dat_in[15:0], wb_sel_in[1:0]);
      end
   end

   // software direction bits, all inputs after reset
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         pin_direction_bit <= 16'h0000;
      end
      else if (wb_wr && hit(wb_adr_in, `PAFP_DIR_ADDR))
      begin
         pin_direction_bit <= merge16(pin_direction_bit, wb_dat_in[15:0], wb_sel_in[1:0]);
      end
   end

   // one alternate function enable per line
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         alt_enable <= 16'h0000;
      end
      else if (wb_wr && hit(wb_adr_in, `PAFP_ALT_EN_ADDR))
      begin
         alt_enable <= merge16(alt_enable, wb_dat_in[15:0], wb_sel_in[1:0]);
      end
   end

   // lines forced to output for functions used right after reset
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         auto_out_mask <= 16'h0000;
      end
      else if (wb_wr && hit(wb_adr_in, `PAFP_AUTO_OUT_ADDR))
      begin
         auto_out_mask <= merge16(auto_out_mask, wb_dat_in[15:0], wb_sel_in[1:0]);
      end
   end

   // read mux; unmapped reads give zero
   always @*
   begin
      next_rdata = 32'h00000000;
      case (wb_adr_in)
         `PAFP_PAD_CTRL_ADDR:
            next_rdata = {24'h000000, dedicated_pad_ctrl};
         `PAFP_LATCH_ADDR:
            next_rdata = {16'h0000, port_latch};
         `PAFP_DIR_ADDR:
            next_rdata = {16'h0000, pin_direction_bit};
         `PAFP_ALT_EN_ADDR:
            next_rdata = {16'h0000, alt_enable};
         `PAFP_PIN_ADDR:
            next_rdata = {16'h0000, alt_in_w};
         `PAFP_AUTO_OUT_ADDR:
            next_rdata = {16'h0000, auto_out_mask};
         default:
            next_rdata = 32'h00000000;
      endcase
   end

   // one-wait-state ack and read data
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end
      else
      begin
         wb_ack_out <= wb_req;
         wb_dat_out <= wb_req ? next_rdata : 32'h00000000;
      end
   end

   // decoded pad driver controls for the strobe pads
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         strobe_edge_sel_out <= `PAFP_EDGE_FAST;
         strobe_drive_sel_out <= `PAFP_DRIVE_HIGH;
         latch_strobe_edge_sel_out <= `PAFP_EDGE_FAST;
         latch_strobe_drive_sel_out <= `PAFP_DRIVE_HIGH;
      end
      else
      begin
         strobe_edge_sel_out <= edge_code(dedicated_pad_ctrl[`PAFP_RW_EDGE_LSB +: 2]);
         strobe_drive_sel_out <= drive_code(dedicated_pad_ctrl[`PAFP_RW_DRIVE_LSB +: 2]);
         latch_strobe_edge_sel_out <= edge_code(dedicated_pad_ctrl[`PAFP_ALE_EDGE_LSB +: 2]);
         latch_strobe_drive_sel_out <= drive_code(dedicated_pad_ctrl[`PAFP_ALE_DRIVE_LSB +: 2]);
      end
   end

   // hardware direction: bus lines follow the bus, after-reset outputs forced on
   always @*
   begin
      hw_dir_en = (alt_enable & {16{bus_active_in}}) | auto_out_mask;
   end

   genvar i;
   generate
      for (i = 0; i < `PAFP_PINS; i = i + 1)
      begin : g_pin
         pafp_pin_cell u_cell
         (
            .clk_sys_in(clk_sys_in),
            .rst_n_in(rst_n_in),
            .latch_in(port_latch[i]),
            .dir_in(pin_direction_bit[i]),
            .alt_en_in(alt_enable[i]),
            .alt_pwm_in(alt_pwm_in[i]),
            .alt_data_in(alt_data_in[i]),
            .hw_dir_en_in(hw_dir_en[i]),
            .hw_dir_in(auto_out_mask[i] | bus_drive_in),
            .pad_in(pad_in[i]),
            .pad_out(pad_out_w[i]),
            .pad_oe_out(pad_oe_w[i]),
            .alt_in_out(alt_in_w[i])
         );
      end
   endgenerate

   assign pad_out = pad_out_w;
   assign pad_oe_out = pad_oe_w;
   assign alt_in_out = alt_in_w;
endmodule
`default_nettype wire

// ===== pafp_map.vh
// Summary of operation
// - dedicated strobe pad control register at short address 55h, reset 00h
// - read/write strobe edge: 00 fast, 01 slow about 60 ns, others reserved
// - read/write strobe drive: 00 high, 01 dynamic, 10 low, 11 reserved
// - latch strobe edge uses same encoding: fast or slow about 60 ns
// - latch strobe drive: 00 high, 01 dynamic, 10 low, 11 reserved
// - each port line has exactly one alternate function beside general use
// - direction 0 keeps pin high-impedance; alternate output only when direction 1
// - signals needed right after reset are made outputs automatically; here auto_out_mask resets to 0 and must be set by software
// - alternate output pin value is port latch AND alternate data, except pwm
// - all direction bits reset to 0, pins start as inputs
// - output pin with alternate input feeds latch value to that input; here it feeds the driven pin value, latch AND alt data when enabled, alt data for pwm
// - hardware switches direction automatically for muxed bus pins when enabled
// - pins not used by alternate functions remain general purpose io
// - two lowest ports serve as external address and data lines
// - port 4 drives segment address bits a16 to a23 when segmentation on
// - port 2 also carries fast external interrupts and timer 7 input
// - word read of 8-bit pad control returns zero in bits 15 to 8
`ifndef PAFP_MAP_VH
`define PAFP_MAP_VH
`define PAFP_PAD_CTRL_SHORT 8'h55
`define PAFP_PAD_CTRL_ADDR 16'hf0aa
`define PAFP_LATCH_ADDR 16'hf100
`define PAFP_DIR_ADDR 16'hf104
`define PAFP_ALT_EN_ADDR 16'hf108
`define PAFP_PIN_ADDR 16'hf10c
`define PAFP_AUTO_OUT_ADDR 16'hf110
`define PAFP_PAD_CTRL_RESET 8'h00
`define PAFP_RW_EDGE_LSB 0
`define PAFP_RW_DRIVE_LSB 2
`define PAFP_ALE_EDGE_LSB 4
`define PAFP_ALE_DRIVE_LSB 6
`define PAFP_EDGE_FAST 2'h0
`define PAFP_EDGE_SLOW 2'h1
`define PAFP_DRIVE_HIGH 2'h0
`define PAFP_DRIVE_DYN 2'h1
`define PAFP_DRIVE_LOW 2'h2
`define PAFP_SLOW_EDGE_NS 60
`define PAFP_CLK_NS 100
`define PAFP_SLOW_EDGE_CYC ((`PAFP_SLOW_EDGE_NS + `PAFP_CLK_NS - 1) / `PAFP_CLK_NS)
`define PAFP_PINS 16
`endif

// ===== pafp_pin_cell.v
`timescale 1ns/1ps
`default_nettype none
// one port line: general io plus exactly one alternate function
module pafp_pin_cell
(
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire latch_in,
   input wire dir_in,
   input wire alt_en_in,
   input wire alt_pwm_in,
   input wire alt_data_in,
   input wire hw_dir_en_in,
   input wire hw_dir_in,
   input wire pad_in,
   output reg pad_out,
   output reg pad_oe_out,
   output reg alt_in_out
);
   reg next_out;
   reg next_oe;
   // effective direction and pin value for this line
   always @*
   begin
      next_oe = hw_dir_en_in ? hw_dir_in : dir_in;
      if (alt_en_in && alt_pwm_in)
         next_out = alt_data_in;
      else if (alt_en_in)
         next_out = latch_in & alt_data_in;
      else
         next_out = latch_in;
   end
   // registered pin drive; input side sees the driven pin value when driving
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         pad_out <= 1'b0;
         pad_oe_out <= 1'b0;
         alt_in_out <= 1'b0;
      end
      else
      begin
         pad_out <= next_out;
         pad_oe_out <= next_oe;
         alt_in_out <= next_oe ? next_out : pad_in;
      end
   end
endmodule
`default_nettype wire

// ===== pafp_port_alt_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pafp_map.vh"
// bus answer timing, read data and pad code decodes
module pafp_chk
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic [15:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [15:0] pad_oe_out,
   input wire logic [1:0] strobe_edge_sel_out,
   input wire logic [1:0] strobe_drive_sel_out,
   input wire logic [1:0] latch_strobe_edge_sel_out,
   input wire logic [1:0] latch_strobe_drive_sel_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   chk_ack_follows_req: assert property (
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack one cycle after request");
   chk_ack_one_cycle: assert property (
      wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
   chk_ack_has_cause: assert property (
      wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
   chk_idle_data: assert property (
      !wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
   chk_upper_zero: assert property (
      wb_ack_out && $past(wb_adr_in) == `PAFP_PAD_CTRL_ADDR |-> wb_dat_out[31:8] == 24'h0)
      else $error("pad register upper bits not zero");
   chk_rw_edge: assert property (strobe_edge_sel_out[1] == 1'b0) else $error("rw edge code");
   chk_rw_drive: assert property (strobe_drive_sel_out != 2'h3) else $error("rw drive code");
   chk_ale_edge: assert property (latch_strobe_edge_sel_out[1] == 1'b0) else $error("ale edge code");
   chk_ale_drive: assert property (latch_strobe_drive_sel_out != 2'h3) else $error("ale drive code");
   chk_reset_input: assert property (disable iff (1'b0)
      !rst_n_in |=> pad_oe_out == 16'h0) else $error("pins drive after reset");
endmodule
bind pafp_port_alt_ctrl pafp_chk CHK (.clk_sys_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_adr_in, .wb_dat_out,
   .wb_ack_out, .pad_oe_out, .strobe_edge_sel_out, .strobe_drive_sel_out, .latch_strobe_edge_sel_out,
   .latch_strobe_drive_sel_out);
`default_nettype wire

// ===== pafp_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
// outside parts drive every line the design releases
module pafp_ext_dev
(
   input wire logic [15:0] pad_out_in,
   input wire logic [15:0] pad_oe_in,
   input wire logic [15:0] level_in,
   output logic [15:0] pad_in_out
);
   assign pad_in_out = (pad_out_in & pad_oe_in) | (level_in & ~pad_oe_in);
endmodule
`default_nettype wire

// ===== pafp_port_alt_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pafp_map.vh"
module pafp_port_alt_ctrl_tb;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic bus_active_in = 1'b0, bus_drive_in = 1'b0, wb_ack_out;
   logic [15:0] wb_adr_in = 16'h0, alt_data_in = 16'h0, alt_pwm_in = 16'h0, lvl = 16'h3c96;
   logic [15:0] pad_in, pad_out, pad_oe_out, alt_in_out;
   logic [3:0] wb_sel_in = 4'hf;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic [1:0] strobe_edge_sel_out, strobe_drive_sel_out, latch_strobe_edge_sel_out, latch_strobe_drive_sel_out;
   logic [7:0] v;
   int err_count = 0, total_checks = 0;
   // system clock, 100 ns period
   initial forever #50 clk_sys_in = ~clk_sys_in;
   pafp_port_alt_ctrl DUT (.clk_sys_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
      .wb_dat_in, .wb_dat_out, .wb_ack_out, .alt_data_in, .alt_pwm_in, .bus_active_in, .bus_drive_in, .pad_in,
      .pad_out, .pad_oe_out, .alt_in_out, .strobe_edge_sel_out, .strobe_drive_sel_out, .latch_strobe_edge_sel_out,
      .latch_strobe_drive_sel_out);
   pafp_ext_dev EXT (.pad_out_in(pad_out), .pad_oe_in(pad_oe_out), .level_in(lvl), .pad_in_out(pad_in));
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1 && ++n < 20);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      if (n >= 20) begin err_count++; close_out; end
   endtask
   task rd(input logic [15:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // pins settle two registered stages after a change
   task st;
      repeat (3) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   task t_reset;
      rd(`PAFP_PAD_CTRL_ADDR, 32'h0);
      rd(`PAFP_DIR_ADDR, 32'h0);
      chk(pad_oe_out, 32'h0);
      $display("reset test done");
   endtask
   // every code in every field, fields rotated to expose layout
   task t_pad;
      for (int c = 0; c < 4; c++)
      begin
         v = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
         wb(1'b1, `PAFP_PAD_CTRL_ADDR, {24'hffffff, v});
         st;
         rd(`PAFP_PAD_CTRL_ADDR, {24'h0, v});
         chk(strobe_edge_sel_out, {1'b0, v[1:0] == 2'h1});
         chk(strobe_drive_sel_out, v[3:2] == 2'h3 ? 2'h0 : v[3:2]);
         chk(latch_strobe_edge_sel_out, {1'b0, v[5:4] == 2'h1});
         chk(latch_strobe_drive_sel_out, v[7:6] == 2'h3 ? 2'h0 : v[7:6]);
      end
      $display("pad test done");
   endtask
   task t_unmap;
      wb(1'b1, 16'hf200, 32'hffff);
      rd(16'hf200, 32'h0);
      $display("unmapped test done");
   endtask
   task t_alt;
      @(posedge clk_sys_in);
      alt_data_in <= 16'ha5a5;
      wb(1'b1, `PAFP_LATCH_ADDR, 32'hffff);
      wb(1'b1, `PAFP_DIR_ADDR, 32'hffff);
      wb(1'b1, `PAFP_ALT_EN_ADDR, 32'hffff);
      st;
      chk(pad_out, 32'ha5a5);
      chk(pad_oe_out, 32'hffff);
      @(posedge clk_sys_in);
      alt_pwm_in <= 16'h00ff;
      wb(1'b1, `PAFP_LATCH_ADDR, 32'h0f0f);
      st;
      chk(pad_out, 32'h05a5);
      wb(1'b1, `PAFP_DIR_ADDR, 32'h0);
      st;
      chk(pad_oe_out, 32'h0);
      chk(alt_in_out, lvl);
      wb(1'b1, `PAFP_ALT_EN_ADDR, 32'h0);
      wb(1'b1, `PAFP_LATCH_ADDR, 32'h1234);
      wb(1'b1, `PAFP_DIR_ADDR, 32'hffff);
      st;
      chk(pad_out, 32'h1234);
      chk(alt_in_out, 32'h1234);
      $display("alternate test done");
   endtask
   task t_bus;
      wb(1'b1, `PAFP_DIR_ADDR, 32'h0);
      wb(1'b1, `PAFP_ALT_EN_ADDR, 32'h00ff);
      bus_active_in <= 1'b1;
      bus_drive_in <= 1'b1;
      st;
      chk(pad_oe_out, 32'h00ff);
      @(posedge clk_sys_in);
      bus_drive_in <= 1'b0;
      st;
      chk(pad_oe_out, 32'h0);
      @(posedge clk_sys_in);
      bus_active_in <= 1'b0;
      wb(1'b1, `PAFP_AUTO_OUT_ADDR, 32'h000f);
      st;
      chk(pad_oe_out, 32'h000f);
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      st;
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      st;
      chk(pad_oe_out, 32'h0);
      rd(`PAFP_PAD_CTRL_ADDR, 32'h0);
      $display("bus test done");
   endtask
   // reset for six cycles, then the scenarios
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset;
      t_pad;
      t_unmap;
      t_alt;
      t_bus;
      close_out;
   end
endmodule
`default_nettype wire
